// file: rtl/ctf_fault_bank.sv
// Purpose: PMBus current and temperature fault threshold bank
// Assumes: Sense inputs are linear-format words on clk_sys
// Notes:   SCL and SDA are oversampled by clk_sys
//
// Summary of operation
// - Retry delay is (field+1) x 35 ms
// - Retry field all ones retries forever
// - Over-current limit checked per phase
// - Under-current limit checked per phase
// - Over-temperature limit declares the fault
// - Every fault pulls alert, sets status
// - Response 10 disables output then retries
// - Retry field sets the restart attempt count
// - Retry field zero latches output off
// - Byte action register, word threshold registers
`timescale 1ns/10ps
module ctf_fault_bank
  import ctf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int         MS_COUNT = MS_CYCLES
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // PMBus pins
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        busAlertLineIn,
  output logic             busAlertLineOut,
  output logic             busAlertLineOe,
  // Sensing
  input  wire logic [15:0] phaseCurrentA,
  input  wire logic [15:0] phaseCurrentB,
  input  wire logic [15:0] temperature,
  // Power stage control
  input  wire logic        enableRequest,
  output logic             powerOn,
  output logic [2:0]       faultFlags
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Linear word to fixed point scaled by 2^16; exponent+16 is MSB flip
  function automatic logic signed [47:0] linToFix(input logic [15:0] v);
    logic signed [47:0] m;
    m = {{37{v[10]}}, v[10:0]};
    return m <<< {~v[15], v[14:11]};
  endfunction : linToFix

  function automatic logic isWordCmd(input logic [7:0] c);
    return (c == CMD_OC_LIM) || (c == CMD_UC_LIM) || (c == CMD_OT_LIM);
  endfunction : isWordCmd

  // ************************************************************
  // Declarations
  // ************************************************************
  ctf_bus_e   busSt, next_busSt;
  ctf_pwr_e   pwrSt, next_pwrSt;
  logic [3:0]  bitCnt, next_bitCnt;
  logic        ackPh, next_ackPh;
  logic        sdaDrv, next_sdaDrv;
  logic [7:0]  shReg, next_shReg;
  logic [7:0]  txByte, next_txByte;
  logic [7:0]  cmd, next_cmd;
  logic        byteIdx, next_byteIdx;
  logic [7:0]  loByte, next_loByte;
  logic        clrPulse, next_clrPulse;
  logic [15:0] ocLim, next_ocLim;
  logic [15:0] ucLim, next_ucLim;
  logic [15:0] otLim, next_otLim;
  logic [7:0]  otAct, next_otAct;
  logic [2:0]  next_faultFlags;
  logic        inRetry, next_inRetry;
  logic [2:0]  retriesLeft, next_retriesLeft;
  logic        tmStart, next_tmStart;
  logic        next_powerOn;
  logic [1:0]  pinLvl, pinRise, pinFall;
  logic        sclRise, sclFall, sdaS, startCond, stopCond;
  logic [15:0] rdWord;
  logic        ocCond, ucCond, otCond, tmDone;
  logic [2:0]  cntF, avail;

  // ************************************************************
  // Pin conditioning and retry timer
  // ************************************************************
  ctf_pin_sync #(.W(2)) uSync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   ({scl, sdaIn}),
    .level   (pinLvl),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  ctf_retry_timer #(.MS_COUNT(MS_COUNT)) uTimer (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .start     (tmStart),
    .retryTime (otAct[RTIME_LO +: 3]),
    .done      (tmDone)
  );

  // Bus conditions; SCL high while SDA moves marks start or stop
  assign sclRise   = pinRise[1];
  assign sclFall   = pinFall[1];
  assign sdaS      = pinLvl[0];
  assign startCond = pinLvl[1] && pinFall[0];
  assign stopCond  = pinLvl[1] && pinRise[0];

  // Open-drain pins only ever pull low
  assign sdaOut          = 1'b0;
  assign sdaOe           = sdaDrv;
  assign busAlertLineOut = 1'b0;
  assign busAlertLineOe  = |faultFlags;

  // ************************************************************
  // Fault detection
  // ************************************************************
  // Each phase compared alone, so either phase past the setting trips
  assign ocCond = (linToFix(phaseCurrentA) > linToFix(ocLim)) ||
                  (linToFix(phaseCurrentB) > linToFix(ocLim));
  assign ucCond = (linToFix(phaseCurrentA) < linToFix(ucLim)) ||
                  (linToFix(phaseCurrentB) < linToFix(ucLim));
  assign otCond = linToFix(temperature) > linToFix(otLim);

  // ************************************************************
  // Read data selection
  // ************************************************************
  always_comb
  begin
    unique case (cmd)
      CMD_OC_LIM: rdWord = ocLim;
      CMD_UC_LIM: rdWord = ucLim;
      CMD_OT_LIM: rdWord = otLim;
      CMD_OT_ACT: rdWord = {otAct, otAct};
      CMD_STATUS: rdWord = {5'h00, faultFlags, 5'h00, faultFlags};
      default:    rdWord = 16'hFFFF;
    endcase
  end

  // ************************************************************
  // PMBus slave engine
  // ************************************************************
  // Decisions are made at the SCL fall that opens each ack slot
  always_comb
  begin
    next_busSt    = busSt;
    next_bitCnt   = bitCnt;
    next_ackPh    = ackPh;
    next_sdaDrv   = sdaDrv;
    next_shReg    = shReg;
    next_txByte   = txByte;
    next_cmd      = cmd;
    next_byteIdx  = byteIdx;
    next_loByte   = loByte;
    next_clrPulse = 1'b0;
    next_ocLim    = ocLim;
    next_ucLim    = ucLim;
    next_otLim    = otLim;
    next_otAct    = otAct;
    if (startCond)
    begin
      next_busSt  = BUS_ADDR;
      next_bitCnt = 4'h0;
      next_ackPh  = 1'b0;
      next_sdaDrv = 1'b0;
    end
    else if (stopCond)
    begin
      next_busSt  = BUS_IDLE;
      next_sdaDrv = 1'b0;
    end
    else if (busSt == BUS_RD)
    begin
      if (!ackPh)
      begin
        if (sclRise)
          next_bitCnt = bitCnt + 4'h1;
        if (sclFall && bitCnt == 4'h8)
        begin
          next_ackPh  = 1'b1;
          next_sdaDrv = 1'b0;
        end
        else if (sclFall)
        begin
          next_txByte = {txByte[6:0], 1'b0};
          next_sdaDrv = !txByte[6];
        end
      end
      else
      begin
        // Master NACK ends the read; wait for stop released
        if (sclRise && sdaS)
          next_busSt = BUS_IDLE;
        if (sclFall)
        begin
          next_ackPh   = 1'b0;
          next_bitCnt  = 4'h0;
          next_byteIdx = 1'b1;
          next_txByte  = rdWord[15:8];
          next_sdaDrv  = !rdWord[15];
        end
      end
    end
    else if (busSt != BUS_IDLE)
    begin
      if (!ackPh)
      begin
        if (sclRise && bitCnt != 4'h8)
        begin
          next_shReg  = {shReg[6:0], sdaS};
          next_bitCnt = bitCnt + 4'h1;
        end
        if (sclFall && bitCnt == 4'h8)
        begin
          next_ackPh = 1'b1;
          unique case (busSt)
            BUS_ADDR: next_sdaDrv = (shReg[7:1] == DEV_ADDR);
            BUS_CMD:
            begin
              next_cmd      = shReg;
              next_byteIdx  = 1'b0;
              next_sdaDrv   = isWordCmd(shReg) || shReg == CMD_OT_ACT ||
                              shReg == CMD_STATUS || shReg == CMD_CLEAR;
              next_clrPulse = (shReg == CMD_CLEAR);
            end
            default:
            begin
              if (!byteIdx)
              begin
                next_loByte = shReg;
                next_sdaDrv = isWordCmd(cmd) || cmd == CMD_OT_ACT;
                if (cmd == CMD_OT_ACT)
                  next_otAct = shReg;
              end
              else
              begin
                next_sdaDrv = isWordCmd(cmd);
                if (cmd == CMD_OC_LIM)
                  next_ocLim = {shReg, loByte};
                if (cmd == CMD_UC_LIM)
                  next_ucLim = {shReg, loByte};
                if (cmd == CMD_OT_LIM)
                  next_otLim = {shReg, loByte};
              end
            end
          endcase
        end
      end
      else if (sclFall)
      begin
        next_ackPh  = 1'b0;
        next_bitCnt = 4'h0;
        next_sdaDrv = 1'b0;
        if (!sdaDrv)
          next_busSt = BUS_IDLE;
        else if (busSt == BUS_ADDR && shReg[0])
        begin
          next_busSt   = BUS_RD;
          next_byteIdx = 1'b0;
          next_txByte  = rdWord[7:0];
          next_sdaDrv  = !rdWord[7];
        end
        else if (busSt == BUS_ADDR)
          next_busSt = BUS_CMD;
        else if (busSt == BUS_CMD)
          next_busSt = BUS_WR;
        else
          next_byteIdx = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      busSt    <= BUS_IDLE;
      bitCnt   <= 4'h0;
      ackPh    <= 1'b0;
      sdaDrv   <= 1'b0;
      shReg    <= 8'h00;
      txByte   <= 8'h00;
      cmd      <= 8'h00;
      byteIdx  <= 1'b0;
      loByte   <= 8'h00;
      clrPulse <= 1'b0;
      ocLim    <= OC_LIM_RST;
      ucLim    <= UC_LIM_RST;
      otLim    <= OT_LIM_RST;
      otAct    <= OT_ACT_RST;
    end
    else
    begin
      busSt    <= next_busSt;
      bitCnt   <= next_bitCnt;
      ackPh    <= next_ackPh;
      sdaDrv   <= next_sdaDrv;
      shReg    <= next_shReg;
      txByte   <= next_txByte;
      cmd      <= next_cmd;
      byteIdx  <= next_byteIdx;
      loByte   <= next_loByte;
      clrPulse <= next_clrPulse;
      ocLim    <= next_ocLim;
      ucLim    <= next_ucLim;
      otLim    <= next_otLim;
      otAct    <= next_otAct;
    end
  end

  // ************************************************************
  // Status flags and power sequencing
  // ************************************************************
  assign cntF  = otAct[RCNT_LO +: 3];
  assign avail = inRetry ? retriesLeft : cntF;

  // Flags stay set while a condition persists, so a set beats a clear
  always_comb
  begin
    next_faultFlags           = clrPulse ? 3'h0 : faultFlags;
    next_faultFlags[STAT_OC]  = next_faultFlags[STAT_OC] | ocCond;
    next_faultFlags[STAT_UC]  = next_faultFlags[STAT_UC] | ucCond;
    next_faultFlags[STAT_OT]  = next_faultFlags[STAT_OT] | otCond;
    next_pwrSt       = pwrSt;
    next_inRetry     = inRetry;
    next_retriesLeft = retriesLeft;
    next_tmStart     = 1'b0;
    unique case (pwrSt)
      PW_OFF:
      begin
        next_inRetry = 1'b0;
        if (enableRequest)
          next_pwrSt = PW_RUN;
      end
      PW_RUN:
      begin
        if (!enableRequest)
          next_pwrSt = PW_OFF;
        else if (otCond && otAct[RESP_LO +: 2] == RESP_RETRY)
        begin
          if (cntF == RCNT_FOREVER)
          begin
            next_pwrSt   = PW_WAIT;
            next_tmStart = 1'b1;
          end
          else if (avail == 3'h0)
            next_pwrSt = PW_LATCH;
          else
          begin
            next_retriesLeft = avail;
            next_pwrSt       = PW_WAIT;
            next_tmStart     = 1'b1;
          end
        end
        else if (otCond && otAct[RESP_LO +: 2] == RESP_LATCH)
          next_pwrSt = PW_LATCH;
        else if (!otCond)
          next_inRetry = 1'b0;
      end
      PW_WAIT:
      begin
        if (!enableRequest)
          next_pwrSt = PW_OFF;
        else if (tmDone)
        begin
          next_pwrSt   = PW_RUN;
          next_inRetry = 1'b1;
          if (cntF != RCNT_FOREVER)
            next_retriesLeft = retriesLeft - 3'h1;
        end
      end
      PW_LATCH:
      begin
        if (!enableRequest)
          next_pwrSt = PW_OFF;
        else if (clrPulse && !otCond)
        begin
          next_pwrSt   = PW_RUN;
          next_inRetry = 1'b0;
        end
      end
    endcase
    next_powerOn = (next_pwrSt == PW_RUN);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      faultFlags  <= 3'h0;
      pwrSt       <= PW_OFF;
      inRetry     <= 1'b0;
      retriesLeft <= 3'h0;
      tmStart     <= 1'b0;
      powerOn     <= 1'b0;
    end
    else
    begin
      faultFlags  <= next_faultFlags;
      pwrSt       <= next_pwrSt;
      inRetry     <= next_inRetry;
      retriesLeft <= next_retriesLeft;
      tmStart     <= next_tmStart;
      powerOn     <= next_powerOn;
    end
  end

endmodule : ctf_fault_bank

// file: rtl/ctf_pin_sync.sv
// Purpose: Two-flop synchroniser with edge detection
// Assumes: Inputs asynchronous to clk_sys
// Notes:   Edges come from the second and third flops only
`timescale 1ns/10ps
module ctf_pin_sync
  import ctf_pkg::*;
#(
  parameter int W = 2
)(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Pins and conditioned copies
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;
  logic [W-1:0] next_stage3;

  // Shift chain; released bus lines idle high
  always_comb
  begin
    next_stage1 = pinIn;
    next_stage2 = stage1;
    next_stage3 = stage2;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;

endmodule : ctf_pin_sync

// file: rtl/ctf_pkg.sv
// Purpose: Shared constants and types for the fault threshold bank
// Assumes: 100 MHz system clock
// Notes:   Command codes are the PMBus command bytes
package ctf_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] CMD_CLEAR  = 8'h03;
  localparam logic [7:0] CMD_OC_LIM = 8'h46;
  localparam logic [7:0] CMD_UC_LIM = 8'h4B;
  localparam logic [7:0] CMD_OT_LIM = 8'h4F;
  localparam logic [7:0] CMD_OT_ACT = 8'h50;
  localparam logic [7:0] CMD_STATUS = 8'h7D;

  // ************************************************************
  // Reset values and fields
  // ************************************************************
  localparam logic [15:0] OC_LIM_RST  = 16'h0000;
  localparam logic [15:0] UC_LIM_RST  = 16'h0000;
  localparam logic [15:0] OT_LIM_RST  = 16'h0000;
  localparam logic [7:0]  OT_ACT_RST  = 8'h00;
  localparam int          RESP_LO     = 6;
  localparam int          RCNT_LO     = 3;
  localparam int          RTIME_LO    = 0;
  localparam logic [1:0]  RESP_RETRY  = 2'h2;
  localparam logic [1:0]  RESP_LATCH  = 2'h3;
  localparam logic [2:0]  RCNT_FOREVER = 3'h7;
  localparam int          STAT_OC     = 0;
  localparam int          STAT_UC     = 1;
  localparam int          STAT_OT     = 2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int RETRY_STEP_MS = 35;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_CMD, BUS_WR, BUS_RD} ctf_bus_e;
  typedef enum logic [1:0] {PW_OFF, PW_RUN, PW_WAIT, PW_LATCH} ctf_pwr_e;

endpackage : ctf_pkg

// file: rtl/ctf_retry_timer.sv
// Purpose: Restart delay of (field + 1) x 35 ms
// Assumes: start is a one-cycle pulse
// Notes:   A new start restarts the count
`timescale 1ns/10ps
module ctf_retry_timer
  import ctf_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
)(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control
  input  wire logic       start,
  input  wire logic [2:0] retryTime,
  output logic            done
);

  localparam int PW = $clog2(MS_COUNT + 1);

  logic          running;
  logic [PW-1:0] preCnt;
  logic [8:0]    msCnt;
  logic [8:0]    target;
  logic          next_running;
  logic [PW-1:0] next_preCnt;
  logic [8:0]    next_msCnt;
  logic          next_done;

  // Last millisecond index of the selected delay
  assign target = 9'(({6'h00, retryTime} + 9'h001) * 9'(RETRY_STEP_MS) - 9'h001);

  // Millisecond prescaler and millisecond count
  always_comb
  begin
    next_running = running;
    next_preCnt  = preCnt;
    next_msCnt   = msCnt;
    next_done    = 1'b0;
    if (start)
    begin
      next_running = 1'b1;
      next_preCnt  = '0;
      next_msCnt   = '0;
    end
    else if (running)
    begin
      if (preCnt == PW'(MS_COUNT - 1))
      begin
        next_preCnt = '0;
        if (msCnt == target)
        begin
          next_running = 1'b0;
          next_done    = 1'b1;
        end
        else
        begin
          next_msCnt = msCnt + 9'h001;
        end
      end
      else
      begin
        next_preCnt = preCnt + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      running <= 1'b0;
      preCnt  <= '0;
      msCnt   <= '0;
      done    <= 1'b0;
    end
    else
    begin
      running <= next_running;
      preCnt  <= next_preCnt;
      msCnt   <= next_msCnt;
      done    <= next_done;
    end
  end

endmodule : ctf_retry_timer

// file: verification/ctf_fault_bank_props.sv
// Purpose: Port-level checks of the fault threshold bank
// Assumes: MS_COUNT equals the bound instance value
// Notes:   Limits are internal, so outputs are tied to each other
`timescale 1ns/10ps
module ctf_fault_bank_props
  import ctf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int         MS_COUNT = MS_CYCLES
)(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // PMBus pins
  input wire logic        scl,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        busAlertLineIn,
  input wire logic        busAlertLineOut,
  input wire logic        busAlertLineOe,
  // Sensing and power
  input wire logic [15:0] phaseCurrentA,
  input wire logic [15:0] phaseCurrentB,
  input wire logic [15:0] temperature,
  input wire logic        enableRequest,
  input wire logic        powerOn,
  input wire logic [2:0]  faultFlags
);
  // ****************
  // Helpers
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] offCnt;
  logic [31:0] next_offCnt;
  // Cycles spent with the output off
  always_comb next_offCnt = powerOn ? 32'h0 : offCnt + 32'h1;
  always_ff @(posedge clk_sys) offCnt <= rst ? 32'h0 : next_offCnt;
  sequence shutOff;
    $fell(powerOn) ##0 faultFlags[STAT_OT];
  endsequence
  sequence restart;
    $rose(powerOn) ##0 faultFlags[STAT_OT];
  endsequence
  chk_rst_quiet: assert property (disable iff (1'b0) rst |=>
    !powerOn && faultFlags == 3'h0 && !sdaOe && !busAlertLineOe) else $error("reset state");
  chk_alert_flags: assert property (busAlertLineOe == (|faultFlags) && !busAlertLineOut)
    else $error("alert not flags");
  chk_sda_slot: assert property ($changed(sdaOe) |-> !scl) else $error("sda moved");
  chk_off_cause: assert property ($fell(powerOn) |->
    faultFlags[STAT_OT] || !$past(enableRequest)) else $error("bad shutdown");
  chk_en_off: assert property (!enableRequest |=> !powerOn) else $error("on when off");
  chk_off_hold: assert property (shutOff |=> !powerOn [*8]) else $error("early on");
  chk_retry_gap: assert property (restart |-> offCnt >= 35 * MS_COUNT)
    else $error("short retry");
  chk_flag_drop: assert property (|($past(faultFlags) & ~faultFlags) |-> !scl)
    else $error("flag lost");
endmodule : ctf_fault_bank_props
bind ctf_fault_bank ctf_fault_bank_props #(.DEV_ADDR(DEV_ADDR), .MS_COUNT(MS_COUNT))
  u_ctf_fault_bank_props (.clk_sys(clk_sys), .rst(rst), .scl(scl), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .busAlertLineIn(busAlertLineIn),
  .busAlertLineOut(busAlertLineOut), .busAlertLineOe(busAlertLineOe),
  .phaseCurrentA(phaseCurrentA), .phaseCurrentB(phaseCurrentB), .temperature(temperature),
  .enableRequest(enableRequest), .powerOn(powerOn), .faultFlags(faultFlags));

// file: verification/ctf_host_model.sv
// Purpose: PMBus host model that drives SCL and releases or pulls SDA
// Assumes: SDA has a pull-up, SCL idles high between frames
// Notes:   125 ns bit slot, free of the clk_sys phase
`timescale 1ns/10ps
module ctf_host_model (
  // Wire levels
  output logic      scl,
  output logic      sdaRel,
  input  wire logic sdaLine
);
  // ****************
  // Bit and byte moves
  // ****************
  logic nak;
  initial
  begin
    scl    = 1'b1;
    sdaRel = 1'b1;
    nak    = 1'b0;
  end
  // SDA moves only while SCL is low, so no false start or stop
  task automatic slot(input logic b, output logic s);
    #31 sdaRel = b;
    #32 scl = 1'b1;
    #62 s = sdaLine;
    scl = 1'b0;
  endtask : slot
  task automatic put(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    nak = nak | s;
  endtask : put
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(last, s);
  endtask : get
  // Also serves as repeated start
  task automatic start();
    #31 sdaRel = 1'b1;
    #32 scl = 1'b1;
    #62 sdaRel = 1'b0;
    #62 scl = 1'b0;
  endtask : start
  task automatic stop();
    #31 sdaRel = 1'b0;
    #32 scl = 1'b1;
    #62 sdaRel = 1'b1;
    #62;
  endtask : stop
  // Byte action, word limits; n data bytes, low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
    nak = 1'b0;
    start();
    put(8'h80);
    put(cmd);
    if (n > 0) put(d[7:0]);
    if (n > 1) put(d[15:8]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d);
    d = 16'h0000;
    start();
    put(8'h80);
    put(cmd);
    start();
    put(8'h81);
    get(n == 1, d[7:0]);
    if (n > 1) get(1'b1, d[15:8]);
    stop();
  endtask : rd
endmodule : ctf_host_model

// file: verification/tb.sv
// Purpose: Self-checking bench of the fault threshold bank
// Assumes: Sense words use exponent 0, so mantissas compare directly
// Notes:   MS_COUNT cut to 10 cycles to keep retry waits short
`timescale 1ns/10ps
module tb;
  import ctf_pkg::*;
  // ****************
  // Signals and model state
  // ****************
  localparam int MSC = 10;
  logic        clk_sys;
  logic        rst           = 1'b1;
  logic        scl;
  logic        sdaRel;
  logic        sdaOut;
  logic        sdaOe;
  logic        busAlertLineOut;
  logic        busAlertLineOe;
  logic [15:0] phaseCurrentA = 16'h012C;
  logic [15:0] phaseCurrentB = 16'h012C;
  logic [15:0] temperature   = 16'h0019;
  logic        enableRequest = 1'b0;
  logic        powerOn;
  logic [2:0]  faultFlags;
  logic [15:0] rdv;
  logic [7:0]  act;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc    = 0;
  int          rises  = 0;
  int          lowCnt = 0;
  int          gap    = 0;
  int          mf     = 0;
  int          lim[3] = '{0, 0, 0};
  int          phA[5] = '{600, 300, 50, 300, 500};
  int          phB[5] = '{300, 600, 300, 50, 100};
  logic [7:0]  cmdTab[3] = '{CMD_OC_LIM, CMD_UC_LIM, CMD_OT_LIM};
  logic [15:0] rstTab[3] = '{OC_LIM_RST, UC_LIM_RST, OT_LIM_RST};
  logic [7:0]  actTab[5] = '{8'h40, 8'h80, 8'h90, 8'hC8, 8'hB8};
  // Open-drain wires with pull-ups
  wire sdaLine   = sdaRel & ~(sdaOe & ~sdaOut);
  wire alertLine = ~(busAlertLineOe & ~busAlertLineOut);
  ctf_fault_bank #(.MS_COUNT(MSC)) u_ctf_fault_bank (.clk_sys(clk_sys), .rst(rst),
    .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .busAlertLineIn(alertLine), .busAlertLineOut(busAlertLineOut),
    .busAlertLineOe(busAlertLineOe), .phaseCurrentA(phaseCurrentA),
    .phaseCurrentB(phaseCurrentB), .temperature(temperature),
    .enableRequest(enableRequest), .powerOn(powerOn), .faultFlags(faultFlags));
  ctf_host_model u_host (.scl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Restart counter, off-time meter and hang guard
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (powerOn === 1'b1 && lowCnt > 0)
    begin
      rises = rises + 1;
      gap   = lowCnt;
    end
    lowCnt = (powerOn === 1'b1) ? 0 : lowCnt + 1;
    if (cyc == 80000)
    begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks = checks + 1;
    if (seen !== want)
    begin
      n_fail = n_fail + 1;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  // Strict compares, either phase alone trips
  function automatic int cond();
    int a;
    int b;
    a = phaseCurrentA;
    b = phaseCurrentB;
    cond = (int'(temperature) > lim[2]) ? 4 : 0;
    cond = cond + ((a < lim[1] || b < lim[1]) ? 2 : 0);
    cond = cond + ((a > lim[0] || b > lim[0]) ? 1 : 0);
  endfunction : cond
  // Flags are sticky: the model only ORs in new conditions
  task automatic sense(input int a, input int b, input int t);
    @(posedge clk_sys);
    #1 phaseCurrentA = 16'(a);
    phaseCurrentB = 16'(b);
    temperature = 16'(t);
    mf = mf | cond();
    repeat (3) @(posedge clk_sys);
    #1 chk(16'({alertLine, faultFlags}), 16'({mf == 0, 3'(mf)}));
  endtask : sense
  task automatic clr();
    u_host.wr(CMD_CLEAR, 16'h0000, 0);
    mf = cond();
    repeat (3) @(posedge clk_sys);
    #1 chk(16'(faultFlags), 16'(mf));
  endtask : clr
  task automatic wl(input int i, input int v);
    u_host.wr(cmdTab[i], 16'(v), 2);
    chk(16'(u_host.nak), 16'h0000);
    lim[i] = v;
  endtask : wl
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    void'($urandom(91));
    chk(16'(powerOn), 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      u_host.rd(cmdTab[i], 2, rdv);
      chk(rdv, rstTab[i]);
      wl(i, int'(16'($urandom)));
      u_host.rd(cmdTab[i], 2, rdv);
      chk(rdv, 16'(lim[i]));
    end
    u_host.rd(CMD_OT_ACT, 1, rdv);
    chk(rdv, 16'(OT_ACT_RST));
    act = 8'($urandom);
    u_host.wr(CMD_OT_ACT, 16'(act), 1);
    u_host.rd(CMD_OT_ACT, 1, rdv);
    chk(rdv, 16'(act));
    u_host.wr(8'h47, 16'h0000, 1);
    chk(16'(u_host.nak), 16'h0001);
    $display("test registers done");
    wl(0, 500);
    wl(1, 100);
    wl(2, 80);
    clr();
    sense(300, 300, 25);
    @(posedge clk_sys);
    #1 enableRequest = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      sense(phA[i], phB[i], 25);
      u_host.rd(CMD_STATUS, 1, rdv);
      chk(rdv, 16'(mf));
      chk(16'(powerOn), 16'h0001);
      sense(300, 300, 25);
      clr();
    end
    $display("test phases done");
    for (int k = 0; k < 5; k++)
    begin
      int d;
      int n;
      int r;
      act = actTab[k] | ((k == 2) ? 8'($urandom % 8) : 8'h00);
      d = (act[2:0] + 1) * 35 * MSC;
      n = (act[7:6] != RESP_RETRY) ? 0 : (act[5:3] == RCNT_FOREVER) ? 4 : act[5:3];
      u_host.wr(CMD_OT_ACT, 16'(act), 1);
      r = rises;
      sense(300, 300, 90);
      repeat ((n == 4 ? n : n + 2) * (d + 4) + d / 2) @(posedge clk_sys);
      chk(16'(rises - r), 16'(n));
      if (n > 0)
        chk(16'(gap > d && gap < d + 5), 16'h0001);
      if (n == 4)
      begin
        @(posedge clk_sys);
        #1 enableRequest = 1'b0;
        r = rises;
        repeat (2 * d) @(posedge clk_sys);
        chk(16'(rises - r), 16'h0000);
      end
      sense(300, 300, 25);
      repeat (20) @(posedge clk_sys);
      chk(16'(powerOn), 16'(!act[7]));
      clr();
      chk(16'(powerOn), 16'(enableRequest));
      $display("test action %h done", act);
    end
    print_verdict();
  end
endmodule : tb
